// >>> sfcf_pkg.sv
// shared constants and types of the serial flash command front end
package sfcf_pkg;

    // opcodes
    localparam logic [7:0] OPC_LEGACY_ID    = 8'hAB;
    localparam logic [7:0] OPC_STD_ID       = 8'h9F;
    localparam logic [7:0] OPC_ADDR_ID      = 8'h90;
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_OFF    = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OPC_QUICK_READ   = 8'h0B;
    localparam logic [7:0] OPC_TWO_LINE     = 8'h3B;
    localparam logic [7:0] OPC_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OPC_SMALL_ER_A   = 8'hD7;
    localparam logic [7:0] OPC_SMALL_ER_B   = 8'h20;
    localparam logic [7:0] OPC_LARGE_ER     = 8'hD8;
    localparam logic [7:0] OPC_FULL_ER_A    = 8'hC7;
    localparam logic [7:0] OPC_FULL_ER_B    = 8'h60;

    // serial clock pulse counts of a frame
    localparam int         CNT_W        = 13;
    localparam logic [12:0] CNT_MAX      = 13'h1FFF;
    localparam logic [12:0] CNT_OPC_LAST = 13'h0007;
    localparam logic [12:0] CNT_B1_LAST  = 13'h000F;
    localparam logic [12:0] CNT_HDR_LAST = 13'h001F;
    localparam logic [12:0] BITS_OPC     = 13'h0008;
    localparam logic [12:0] BITS_STWR    = 13'h0010;
    localparam logic [12:0] BITS_HDR     = 13'h0020;
    localparam logic [12:0] BITS_PAGE    = 13'h0028;

    // status byte layout and reset values
    localparam int         ST_BUSY  = 0;
    localparam int         ST_WEL   = 1;
    localparam int         ST_BP_LO = 2;
    localparam int         ST_BP_HI = 4;
    localparam int         ST_LOCK  = 7;
    localparam logic [2:0] RST_BP   = 3'h0;
    localparam logic       RST_LOCK = 1'b0;
    localparam logic       RST_WEL  = 1'b0;

    // protected span boundaries, decoded address bits only
    localparam int          ADDR_W      = 19;
    localparam logic [18:0] REG_TOP     = 19'h70000;
    localparam logic [18:0] REG_QUARTER = 19'h60000;
    localparam logic [18:0] REG_HALF    = 19'h40000;
    localparam logic [2:0]  BP_NONE     = 3'h0;
    localparam logic [2:0]  BP_TOP      = 3'h1;
    localparam logic [2:0]  BP_QUARTER  = 3'h2;
    localparam logic [2:0]  BP_HALF     = 3'h3;

    // identification sequence length
    localparam logic [1:0] ID_LAST = 2'h2;

    typedef enum logic [2:0] {
        OP_NONE, OP_PAGE, OP_SMALL, OP_LARGE, OP_FULL
    } sfcf_op_type;

    typedef enum logic [2:0] {
        OUT_STATUS, OUT_LEGACY, OUT_STD, OUT_ADDR_MFR, OUT_ADDR_DEV
    } sfcf_out_type;

endpackage : sfcf_pkg

// >>> sfcf_prot_if.sv
// interface between the front end and its region protection check
`timescale 1ns/1ps
interface sfcf_prot_if;
    logic [2:0]                 bp;
    logic [sfcf_pkg::ADDR_W-1:0] addr;
    logic                       whole;
    logic                       hit;
    modport chk  (input bp, input addr, input whole, output hit);
    modport user (output bp, output addr, output whole, input hit);
endinterface : sfcf_prot_if

// >>> sfcf_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sfcf_sync #(
    parameter int W = 1
) (
    input  logic         clk,    // destination clock
    input  logic         arst_n, // async reset
    input  logic [W-1:0] din,    // foreign level
    output logic [W-1:0] dout    // synchronised level
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule : sfcf_sync

// >>> sfcf_region.sv
// protected span check for program and erase
`timescale 1ns/1ps
module sfcf_region (
    sfcf_prot_if.chk prt // protect bits, address, result
);
    import sfcf_pkg::*;

    // span limits per code; top code bit covers the whole array
    wire in_top     = (prt.addr >= REG_TOP);
    wire in_quarter = (prt.addr >= REG_QUARTER);
    wire in_half    = (prt.addr >= REG_HALF);
    wire zone_hit   = (prt.bp == BP_TOP)     ? in_top :
                      (prt.bp == BP_QUARTER) ? in_quarter :
                      (prt.bp == BP_HALF)    ? in_half : prt.bp[2];
    // full erase is refused while any protect bit is set
    assign prt.hit = prt.whole ? (prt.bp != BP_NONE) : zone_hit;
endmodule : sfcf_region

// >>> sfcf_top.sv
// serial flash command front end: framing, decode, protection, id reads
// Operation
// - program, erase, status write run only if clock pulses are multiple of 8
// - status lock set and protect pin low: status writes ignored
// - program, erase, status write need write enable latch set first
// - program and erase into the protected region are refused
// - protect code: none, top 64K, top quarter, top half, all
// - opcode held in 8-bit register, everything shifted in MSB first
// - serial input sampled on rising serial clock while selected
// - each command is one opcode byte, then address and/or data
// - id opcodes: legacy ABh 4 bytes, standard 9Fh 1, addressed 90h 4
// - array read 03h, four byte header, clock at most 33 MHz
// - quick read 0Bh, five byte header, up to 100 MHz
// - two line read 3Bh, five byte header, up to 100 MHz
// - page write 02h, four byte header plus up to 256 data bytes
// - pause low/high while clock low; sequence state kept
// - paused: output released, input ignored, clocks do not advance
// - legacy id takes three dummy bytes, then returns id bytes
// - legacy id order: first maker, device, second maker, MSB first
// - legacy id sequence repeats while select stays low
// - standard id order: second maker, first maker, device, repeating
// - addressed id: address bit 0 picks maker or device first
// - while busy every command but status read is ignored
`timescale 1ns/1ps
module sfcf_top #(
    parameter logic [7:0] MFR1_ID = 8'h11, // arbitrary value
    parameter logic [7:0] MFR2_ID = 8'h22, // arbitrary value
    parameter logic [7:0] DEV_ID  = 8'h33  // arbitrary value
) (
    input  logic                 clk_sys,            // system clock
    input  logic                 arst_n,             // async reset
    input  logic                 sck_link,           // host serial clock
    input  logic                 select_pin_n,       // frame select
    input  logic                 serial_in_io,       // serial data in
    output logic                 serial_in_io_drv,   // second line data
    output logic                 serial_in_io_en,    // second line enable
    output logic                 serial_out_dat,     // serial data out
    output logic                 serial_out_en,      // serial out enable
    input  logic                 pause_pin_n,        // transfer pause
    input  logic                 write_protect_pin,  // status guard pin
    input  logic                 busy_flag,          // array engine busy
    output logic                 write_enable_latch, // write enabled
    output logic [2:0]           region_protect_bits,// protect code
    output logic                 status_lock_bit,    // status lock
    output logic                 op_start,           // array op pulse
    output sfcf_pkg::sfcf_op_type op_kind,           // array op kind
    output logic [23:0]          op_addr             // array op address
);
    import sfcf_pkg::*;

    // ---------------- link domain ----------------
    logic [CNT_W-1:0] cnt_q;
    logic [7:0]       sh_q;
    logic             out_on_q;
    sfcf_out_type     out_kind_q;
    logic [2:0]       obit_q;
    logic [1:0]       oidx_q;
    logic             out_q;
    logic [7:0]       opc_q;
    logic [23:0]      addr_q;
    logic [7:0]       sdat_q;
    logic [CNT_W-1:0] lbits_q;
    logic             seq_q;
    logic [7:0]       stat_l;

    // frame logic is cleared whenever select is high
    wire lrst_n = arst_n & ~select_pin_n;
    // a paused edge is ignored entirely
    wire adv = pause_pin_n;
    wire [7:0] nxt_byte = {sh_q[6:0], serial_in_io};
    wire [CNT_W-1:0] cnt_nx = (cnt_q == CNT_MAX) ? cnt_q
                                                 : cnt_q + 13'h0001;
    wire busy_l = stat_l[ST_BUSY];

    // status and busy brought onto the serial clock
    sfcf_sync #(.W(8)) u_sync_link (
        .clk    (sck_link),
        .arst_n (arst_n),
        .din    ({status_lock_bit, 2'b00, region_protect_bits,
                  write_enable_latch, busy_flag}),
        .dout   (stat_l)
    );

    // output start decode; id reads refused while busy
    wire opc_end  = (cnt_q == CNT_OPC_LAST);
    wire hdr_end  = (cnt_q == CNT_HDR_LAST);
    wire go_stat  = opc_end & (nxt_byte == OPC_STATUS_READ);
    wire go_std   = opc_end & (nxt_byte == OPC_STD_ID)
                    & ~busy_l;
    wire go_leg   = hdr_end & (opc_q == OPC_LEGACY_ID)
                    & ~busy_l;
    wire go_adr   = hdr_end & (opc_q == OPC_ADDR_ID) & ~busy_l;
    wire go_any   = go_stat | go_std | go_leg | go_adr;
    wire sfcf_out_type go_kind =
        go_stat ? OUT_STATUS :
        go_std  ? OUT_STD    :
        go_leg  ? OUT_LEGACY :
        nxt_byte[0] ? OUT_ADDR_DEV : OUT_ADDR_MFR;

    // frame counter and output sequencer, cleared by select
    always_ff @(posedge sck_link or negedge lrst_n) begin
        if (!lrst_n) begin
            cnt_q      <= '0;
            sh_q       <= 8'h00;
            out_on_q   <= 1'b0;
            out_kind_q <= OUT_STATUS;
            obit_q     <= 3'h0;
            oidx_q     <= 2'h0;
        end else if (adv) begin
            cnt_q <= cnt_nx;
            sh_q  <= nxt_byte;
            if (out_on_q) begin
                obit_q <= obit_q + 3'h1;
                if (obit_q == 3'h7) begin
                    oidx_q <= (oidx_q == ID_LAST) ? 2'h0
                                                  : oidx_q + 2'h1;
                end
            end else if (go_any) begin
                out_on_q   <= 1'b1;
                out_kind_q <= go_kind;
                obit_q     <= 3'h0;
                oidx_q     <= 2'h0;
            end
        end
    end

    // frame snapshot; survives select so the system side can read it
    always_ff @(posedge sck_link or negedge arst_n) begin
        if (!arst_n) begin
            opc_q   <= 8'h00;
            addr_q  <= 24'h000000;
            sdat_q  <= 8'h00;
            lbits_q <= '0;
            seq_q   <= 1'b0;
        end else if (adv) begin
            lbits_q <= cnt_nx;
            if (cnt_q == '0) begin
                seq_q <= ~seq_q;
            end
            if (opc_end) begin
                opc_q <= nxt_byte;
            end
            if ((cnt_q > CNT_OPC_LAST) && (cnt_q <= CNT_HDR_LAST)) begin
                addr_q <= {addr_q[22:0], serial_in_io};
            end
            if (cnt_q == CNT_B1_LAST) begin
                sdat_q <= nxt_byte;
            end
        end
    end

    // identification byte order per output kind
    wire [23:0] id_seq =
        (out_kind_q == OUT_STD)      ? {MFR2_ID, MFR1_ID, DEV_ID} :
        (out_kind_q == OUT_ADDR_DEV) ? {DEV_ID, MFR1_ID, MFR2_ID} :
                                       {MFR1_ID, DEV_ID, MFR2_ID};
    wire [7:0] id_byte = (oidx_q == 2'h0) ? id_seq[23:16] :
                         (oidx_q == 2'h1) ? id_seq[15:8]  : id_seq[7:0];
    wire [7:0] cur_byte = (out_kind_q == OUT_STATUS) ? stat_l : id_byte;

    // data leaves on the falling edge, MSB first
    always_ff @(negedge sck_link or negedge lrst_n) begin
        if (!lrst_n) begin
            out_q <= 1'b0;
        end else if (adv) begin
            out_q <= out_on_q & cur_byte[~obit_q];
        end
    end

    // released while paused or deselected
    assign serial_out_dat   = out_q;
    assign serial_out_en    = out_on_q & pause_pin_n
                              & ~select_pin_n;
    // second line carries array data only, which lives outside this block
    assign serial_in_io_drv = 1'b0;
    assign serial_in_io_en  = 1'b0;

    // ---------------- system domain ----------------
    logic             sel_s;
    logic             wp_s;
    logic             seq_s;
    logic             sel_prev_q;
    logic             seq_seen_q;
    logic             busy_prev_q;
    logic             wel_q;
    logic             wel_d;
    logic [2:0]       bp_q;
    logic             lock_q;
    logic             op_start_q;
    sfcf_op_type      op_kind_q;
    logic [23:0]      op_addr_q;

    // pins and the frame toggle into the system clock
    sfcf_sync #(.W(3)) u_sync_sys (
        .clk    (clk_sys),
        .arst_n (arst_n),
        .din    ({select_pin_n, write_protect_pin, seq_q}),
        .dout   ({sel_s, wp_s, seq_s})
    );

    sfcf_prot_if prt ();
    sfcf_region u_region (
        .prt (prt)
    );

    // a frame ends on select rising; a frame with no clocks is skipped
    wire fire    = sel_s & ~sel_prev_q & (seq_s != seq_seen_q);
    wire whole8  = (lbits_q[2:0] == 3'h0);
    wire gate_w  = wel_q & ~busy_flag & whole8;
    wire has_opc = (lbits_q >= BITS_OPC);

    // erase and program decode; other opcodes fall through
    wire is_page  = (opc_q == OPC_PAGE_WRITE);
    wire is_small = (opc_q == OPC_SMALL_ER_A) | (opc_q == OPC_SMALL_ER_B);
    wire is_large = (opc_q == OPC_LARGE_ER);
    wire is_full  = (opc_q == OPC_FULL_ER_A) | (opc_q == OPC_FULL_ER_B);
    // reads are no-ops here
    wire sfcf_op_type kind_sel =
        is_page  ? OP_PAGE  :
        is_small ? OP_SMALL :
        is_large ? OP_LARGE :
        is_full  ? OP_FULL  : OP_NONE;
    wire len_ok = is_page ? (lbits_q >= BITS_PAGE) :
                  is_full ? has_opc : (lbits_q >= BITS_HDR);

    assign prt.bp    = bp_q;
    assign prt.addr  = addr_q[ADDR_W-1:0];
    assign prt.whole = is_full;

    wire op_go  = fire & gate_w & len_ok & (kind_sel != OP_NONE)
                  & ~prt.hit;
    wire sw_go  = fire & (opc_q == OPC_STATUS_WRITE) & gate_w
                  & (lbits_q >= BITS_STWR)
                  & ~(lock_q & ~wp_s);
    wire en_go  = fire & has_opc & ~busy_flag
                  & (opc_q == OPC_WRITE_ENABLE);
    wire dis_go = fire & has_opc & ~busy_flag
                  & (opc_q == OPC_WRITE_OFF);
    wire busy_fall = busy_prev_q & ~busy_flag;

    // latch clears after a write completes; a set in the same cycle wins
    assign wel_d = en_go ? 1'b1 :
                   (dis_go | sw_go | busy_fall) ? 1'b0 : wel_q;

    // frame tracking and the latch
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_prev_q  <= 1'b0;
            seq_seen_q  <= 1'b0;
            busy_prev_q <= 1'b0;
            wel_q       <= RST_WEL;
        end else begin
            sel_prev_q  <= sel_s;
            busy_prev_q <= busy_flag;
            wel_q       <= wel_d;
            if (fire) begin
                seq_seen_q <= seq_s;
            end
        end
    end

    // status bits, only through an accepted status write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bp_q   <= RST_BP;
            lock_q <= RST_LOCK;
        end else if (sw_go) begin
            bp_q   <= sdat_q[ST_BP_HI:ST_BP_LO];
            lock_q <= sdat_q[ST_LOCK];
        end
    end

    // array operation request to the program and erase engine
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_start_q <= 1'b0;
            op_kind_q  <= OP_NONE;
            op_addr_q  <= 24'h000000;
        end else begin
            op_start_q <= op_go;
            if (op_go) begin
                op_kind_q <= kind_sel;
                op_addr_q <= addr_q;
            end
        end
    end

    assign write_enable_latch  = wel_q;
    assign region_protect_bits = bp_q;
    assign status_lock_bit     = lock_q;
    assign op_start            = op_start_q;
    assign op_kind             = op_kind_q;
    assign op_addr             = op_addr_q;

endmodule : sfcf_top

// >>> sfcf_top_assertions.sv
// concurrent checks on the flash front end ports
`timescale 1ns/1ps
module sfcf_top_chk (
    input logic                  clk_sys,             // sys clock
    input logic                  arst_n,              // reset
    input logic                  sck_link,            // link clock
    input logic                  select_pin_n,        // select
    input logic                  pause_pin_n,         // pause
    input logic                  write_protect_pin,   // guard pin
    input logic                  busy_flag,           // engine busy
    input logic                  serial_out_en,       // out enable
    input logic                  write_enable_latch,  // latch
    input logic [2:0]            region_protect_bits, // protect code
    input logic                  status_lock_bit,     // lock
    input logic                  op_start,            // op pulse
    input sfcf_pkg::sfcf_op_type op_kind,             // op kind
    input logic [23:0]           op_addr              // op address
);
    import sfcf_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // own span decode
    function automatic logic hit(logic [2:0] bp, logic [23:0] a);
        return bp[2] | (bp == BP_TOP && a[18:16] == 3'h7)
            | (bp == BP_QUARTER && a[18:17] == 2'h3)
            | (bp == BP_HALF && a[18]);
    endfunction : hit
    // array op hand-off
    a_start_pulse: assert property (op_start |=> !op_start)
        else $error("long op_start");
    a_start_wel: assert property (op_start |-> write_enable_latch)
        else $error("op without latch");
    a_start_idle: assert property (op_start |-> !$past(busy_flag))
        else $error("op while busy");
    a_start_framed: assert property (
        op_start |-> $past(select_pin_n, 2))
        else $error("op in frame");
    a_region_refuse: assert property (
        op_start |=> !hit(region_protect_bits, op_addr))
        else $error("op in protected span");
    a_full_clean: assert property (
        op_start |=> op_kind != OP_FULL || region_protect_bits == BP_NONE)
        else $error("full erase protected");
    a_kind_hold: assert property (
        !op_start && !$past(op_start) |-> $stable(op_kind) && $stable(op_addr))
        else $error("op fields moved");
    // status guard, pin synced first
    a_lock_guard: assert property (
        !write_protect_pin [*4] ##0 status_lock_bit
        |=> status_lock_bit && $stable(region_protect_bits))
        else $error("locked status changed");
    a_status_wel: assert property (
        $changed(region_protect_bits) || $changed(status_lock_bit)
        |-> $past(write_enable_latch))
        else $error("status write no latch");
    a_wel_busy: assert property (
        $fell(busy_flag) |-> ##[1:2] !write_enable_latch)
        else $error("latch kept");
    a_pause_quiet: assert property (@(posedge sck_link)
        disable iff (!arst_n) !pause_pin_n || select_pin_n |-> !serial_out_en)
        else $error("drive while paused");
    c_page: cover property (op_start && op_kind == OP_PAGE);
    c_lock: cover property ($rose(status_lock_bit));
    c_out: cover property (serial_out_en);
    c_pause: cover property (!pause_pin_n && !select_pin_n);
endmodule : sfcf_top_chk
bind sfcf_top sfcf_top_chk u_chk (.clk_sys, .arst_n, .sck_link,
    .select_pin_n, .pause_pin_n, .write_protect_pin, .busy_flag,
    .serial_out_en, .write_enable_latch, .region_protect_bits,
    .status_lock_bit, .op_start, .op_kind, .op_addr);

// >>> sfcf_host.sv
// host bus master model for the flash front end
`timescale 1ns/1ps
module sfcf_host (
    output logic sck,     // link clock
    output logic sel_n,   // select
    output logic sdi,     // data to device
    output logic pause_n, // pause
    input  logic sdo,     // data from device
    input  logic sdo_en,  // device drives sdo
    output logic en_held  // drive seen in pause
);
    localparam time HALF = 24ns;
    // idle: clock low and still, deselected
    initial begin
        sck = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
        pause_n = 1'b1;
        en_held = 1'b0;
    end
    // pause moves only mid low phase; clock runs on, input is junk
    task automatic hold();
        #(HALF / 2) pause_n = 1'b0;
        repeat (3) begin
            sdi = ~sdi;
            #HALF sck = 1'b1;
            en_held = en_held | sdo_en;
            #HALF sck = 1'b0;
        end
        #(HALF / 2) pause_n = 1'b1;
    endtask : hold
    // nb bits of tx msb first, nr bits back; pause before bit pb
    task automatic xfer(input logic [63:0] tx, input int nb, input int nr,
                        input int pb, output logic [31:0] rx);
        rx = 32'h0;
        sel_n = 1'b0;
        for (int i = 0; i < nb + nr; i++) begin
            if (i == pb) hold();
            sdi = (i < nb) ? tx[63 - i] : ~sdi;
            #HALF sck = 1'b1;
            if (i >= nb) rx = {rx[30:0], sdo};
            #HALF sck = 1'b0;
        end
        #HALF sel_n = 1'b1;
        sdi = ~sdi;
        #(HALF * 24);
    endtask : xfer
endmodule : sfcf_host

// >>> testbench.sv
// self-checking bench of the flash front end
`timescale 1ns/1ps
module testbench;
    import sfcf_pkg::*;
    localparam logic [7:0] M1  = 8'hC3; // arbitrary value
    localparam logic [7:0] M2  = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV = 8'h96; // arbitrary value
    logic        clk_sys, arst_n, busy_flag, write_protect_pin;
    logic        sck_link, select_pin_n, serial_in_io, pause_pin_n;
    logic        serial_out_dat, serial_out_en, en_held;
    logic        write_enable_latch, status_lock_bit, op_start;
    logic [2:0]  region_protect_bits;
    sfcf_op_type op_kind;
    logic [23:0] op_addr;
    int          err_count, checks;
    int          n_start = 0;
    sfcf_top #(.MFR1_ID(M1), .MFR2_ID(M2), .DEV_ID(DEV)) dut (
        .clk_sys, .arst_n, .sck_link, .select_pin_n, .serial_in_io,
        .serial_in_io_drv(), .serial_in_io_en(), .serial_out_dat,
        .serial_out_en, .pause_pin_n, .write_protect_pin, .busy_flag,
        .write_enable_latch, .region_protect_bits, .status_lock_bit,
        .op_start, .op_kind, .op_addr);
    sfcf_host host (.sck(sck_link), .sel_n(select_pin_n),
        .sdi(serial_in_io), .pause_n(pause_pin_n), .sdo(serial_out_dat),
        .sdo_en(serial_out_en), .en_held(en_held));
    // count accepted array ops
    always @(posedge clk_sys) if (op_start === 1'b1) n_start <= n_start + 1;
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic cmd(input logic [63:0] tx, input int nb);
        logic [31:0] r;
        host.xfer(tx, nb, 0, 999, r);
    endtask : cmd
    task automatic sys_in(input logic b, input logic wp);
        @(negedge clk_sys);
        busy_flag = b;
        write_protect_pin = wp;
    endtask : sys_in
    task automatic write_enable_cmd();
        cmd({OPC_WRITE_ENABLE, 56'h0}, 8);
    endtask : write_enable_cmd
    task automatic status_write_cmd(input logic [7:0] d);
        write_enable_cmd();
        cmd({OPC_STATUS_WRITE, d, 48'h0}, 16);
    endtask : status_write_cmd
    // enable, op, then an engine busy pulse if one start is expected
    task automatic prog(input logic [7:0] op, input sfcf_op_type k,
                        input logic [23:0] a, input int nb, input int exp);
        int n0 = n_start;
        write_enable_cmd();
        cmd({op, a, 8'hA5, 24'h0}, nb);
        cmp("op_start count", 32'(exp), 32'(n_start - n0));
        if (exp == 1) begin
            cmp("op_kind", 32'(k), 32'(op_kind));
            if (nb >= 32) cmp("op_addr", 32'(a), 32'(op_addr));
            sys_in(1'b1, write_protect_pin);
            sys_in(1'b0, write_protect_pin);
            repeat (3) @(negedge clk_sys);
            cmp("latch after op", 0, 32'(write_enable_latch));
        end
    endtask : prog
    task automatic t_ids();
        logic [31:0] r;
        host.xfer({OPC_STD_ID, 56'h0}, 8, 32, 999, r);
        cmp("std id", {M2, M1, DEV, M2}, r);
        host.xfer({OPC_LEGACY_ID, 56'h0}, 32, 32, 999, r);
        cmp("legacy id", {M1, DEV, M2, M1}, r);
        host.xfer({OPC_ADDR_ID, 24'h0, 32'h0}, 32, 24, 999, r);
        cmp("addr id even", {8'h0, M1, DEV, M2}, r);
        host.xfer({OPC_ADDR_ID, 24'h1, 32'h0}, 32, 24, 999, r);
        cmp("addr id odd", {8'h0, DEV, M1, M2}, r);
        $display("t_ids done");
    endtask : t_ids
    task automatic t_pause();
        logic [31:0] r;
        host.xfer({OPC_STD_ID, 56'h0}, 8, 24, 4, r);
        cmp("id, hold in opcode", {8'h0, M2, M1, DEV}, r);
        host.xfer({OPC_STD_ID, 56'h0}, 8, 24, 13, r);
        cmp("id, hold in output", {8'h0, M2, M1, DEV}, r);
        cmp("drive in hold", 0, 32'(en_held));
        $display("t_pause done");
    endtask : t_pause
    task automatic t_status();
        logic [31:0] r;
        cmd({OPC_STATUS_WRITE, 8'h8C, 48'h0}, 16);
        cmp("bp without latch", 0, 32'(region_protect_bits));
        write_enable_cmd();
        host.xfer({OPC_STATUS_READ, 56'h0}, 8, 8, 999, r);
        cmp("status byte", 32'h02, r);
        cmd({OPC_STATUS_WRITE, 8'h8C, 48'h0}, 23);
        cmp("bp odd count", 0, 32'(region_protect_bits));
        status_write_cmd(8'h8C);
        cmp("bp written", 3, 32'(region_protect_bits));
        cmp("lock written", 1, 32'(status_lock_bit));
        sys_in(1'b0, 1'b0);
        status_write_cmd(8'h00);
        cmp("bp locked", 3, 32'(region_protect_bits));
        sys_in(1'b0, 1'b1);
        status_write_cmd(8'h00);
        cmp("bp unlocked", 0, 32'(region_protect_bits));
        cmp("lock cleared", 0, 32'(status_lock_bit));
        $display("t_status done");
    endtask : t_status
    task automatic t_prog();
        logic [7:0]  op [9] = '{OPC_SMALL_ER_A, OPC_SMALL_ER_B, OPC_LARGE_ER,
            OPC_FULL_ER_A, OPC_FULL_ER_B, OPC_ARRAY_READ, OPC_QUICK_READ,
            OPC_TWO_LINE, 8'hFF};
        sfcf_op_type k [9] = '{OP_SMALL, OP_SMALL, OP_LARGE, OP_FULL,
            OP_FULL, OP_NONE, OP_NONE, OP_NONE, OP_NONE};
        int          nb [9] = '{32, 32, 32, 8, 8, 32, 40, 40, 8};
        int          n0 = n_start;
        write_enable_cmd();
        cmd({OPC_WRITE_OFF, 56'h0}, 8);
        cmd({OPC_PAGE_WRITE, 24'h000100, 8'h3C, 24'h0}, 40);
        cmp("start without latch", 0, 32'(n_start - n0));
        prog(OPC_PAGE_WRITE, OP_PAGE, 24'h000100, 39, 0);
        prog(OPC_PAGE_WRITE, OP_PAGE, 24'h012345, 40, 1);
        for (int i = 0; i < 9; i++) begin
            prog(op[i], k[i], 24'h001000, nb[i], i < 5);
        end
        $display("t_prog done");
    endtask : t_prog
    task automatic t_region();
        logic [2:0]  bp [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
        logic [23:0] lo [4] = '{24'h070000, 24'h060000, 24'h040000, 24'h0};
        for (int i = 0; i < 4; i++) begin
            status_write_cmd({3'h0, bp[i], 2'h0});
            prog(OPC_LARGE_ER, OP_LARGE, lo[i], 32, 0);
            prog(OPC_FULL_ER_A, OP_FULL, 24'h0, 8, 0);
            if (i < 3) prog(OPC_LARGE_ER, OP_LARGE, lo[i] - 1, 32, 1);
        end
        status_write_cmd(8'h00);
        $display("t_region done");
    endtask : t_region
    task automatic t_busy();
        logic [31:0] r;
        sys_in(1'b1, 1'b1);
        host.xfer({OPC_STATUS_READ, 56'h0}, 8, 8, 999, r);
        cmp("status while busy", 32'h01, r);
        write_enable_cmd();
        cmp("latch while busy", 0, 32'(write_enable_latch));
        sys_in(1'b0, 1'b1);
        $display("t_busy done");
    endtask : t_busy
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    // system clock, 40 ns
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // reset for 8 cycles, then the scenarios
    initial begin
        arst_n = 1'b0;
        busy_flag = 1'b0;
        write_protect_pin = 1'b1;
        err_count = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_ids();
        t_pause();
        t_status();
        t_prog();
        t_region();
        t_busy();
        final_report();
    end
    // watchdog, far past the run's length
    initial begin
        #2ms;
        err_count++;
        final_report();
    end
endmodule : testbench
